// ==== logic/hbcd_core.sv ====
// Four-channel half-bridge gate control with protection and off diagnosis.
// Assumes synchronous analog comparator inputs and an Avalon-MM master.
//
// Implementation choices: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// What this block does
// - Mode bit selects low-side or high-side switching
// - Enable low forces both transistors off
// - Low-side passive: low side follows command
// - Low-side active: command picks low or high
// - High-side passive: high side follows command
// - High-side active: command picks high or low
// - Dead time between alternating high and low
// - Pair flags only affect off diagnosis
// - Filtered overcurrent turns off and flags channel
// - Overtemperature holds outputs off until cooled
// - Overcurrent per channel, overtemp per pair
// - Latch off diagnosis after activation time
// - Active freewheel needs disable; passive needs off
// - Full bridge diagnosis needs both halves off
// - Disturbance filter before diagnosis bits set
// - Diagnosis register refreshes every cycle, read or not
// - Short check depends on mode; open load same
// - Single-channel two-bit prioritised off codes
// - Full-bridge single fault code pairs
// - Full-bridge double fault code pairs
module hbcd_core #(
  parameter int DIAG_ACT_CYC = hbcd_pkg::DIAG_ACT_CYC  // Activation time in cycles
) (
  input  wire logic                      core_clk,            // 25 MHz clock
  input  wire logic                      resetn,              // Async reset, active low
  input  wire logic [2:0]                avs_address,         // Word address
  input  wire logic                      avs_read,            // Read request
  input  wire logic                      avs_write,           // Write request
  input  wire logic [31:0]               avs_writedata,       // Write data
  input  wire logic [3:0]                avs_byteenable,      // Byte lanes
  output var  logic [31:0]               avs_readdata,        // Read data
  output var  logic                      avs_waitrequest,     // Stall
  input  wire logic [3:0]                direct_drive_input,  // Direct on pins per channel
  input  wire hbcd_pkg::hbcd_sense_s [3:0] sense,             // Comparators per channel
  input  wire logic [1:0]                overtemp_pair,       // Overtemperature (hysteresis in sensor)
  output var  hbcd_pkg::hbcd_gate_s [3:0] gate                // Gate drives
);

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  localparam int CW = 13;                                     // Counter width

  typedef struct packed {
    logic [31:0]                      setup;                 // Mode, freewheel, pair flags
    logic [3:0]                       enable;                // Channel enables
    logic [4:0]                       command;               // On commands and pin select
    logic [3:0]                       oc_flag;               // Latched overcurrent
    logic [1:0]                       ot_flag;               // Overtemperature flags
    logic [7:0]                       diag;                  // Off diagnosis codes
    hbcd_pkg::hbcd_phase_e [3:0]      phase;                 // Gate phase
    logic [3:0][4:0]                  dead_cnt;              // Dead time counters
    logic [3:0][3:0]                  oc_cnt;                // Overcurrent filter
    logic [3:0][CW-1:0]               act_cnt;               // Activation timers
    logic [3:0][3:0]                  filt_cnt;              // Disturbance filters
    hbcd_pkg::hbcd_gate_s [3:0]       gate;                  // Registered gates
    logic [31:0]                      rdata;                 // Read data
    logic                             wait_n;                // Answer phase
  } hbcd_state_s;

  hbcd_state_s st_reg;                                        // Current state
  hbcd_state_s st_next;                                       // Next state

  logic [3:0]  want_high;                                     // Desired high gate
  logic [3:0]  want_low;                                      // Desired low gate
  logic [3:0]  on_cmd;                                        // Effective on command
  logic [3:0]  diag_act;                                      // Off diagnosis armed
  logic [3:0]  diag_ready;                                    // Timers expired
  logic [7:0]  live_diag;                                     // Present detection codes
  logic [3:0]  mode;                                          // Switch mode per channel
  logic [3:0]  free;                                          // Active freewheel per channel
  logic [1:0]  fb_en;                                         // Full bridge flags

  assign mode  = st_reg.setup[hbcd_pkg::SETUP_MODE_LSB +: 4];
  assign free  = st_reg.setup[hbcd_pkg::SETUP_FREE_LSB +: 4];
  assign fb_en = {st_reg.setup[hbcd_pkg::SETUP_FBB_BIT],
                  st_reg.setup[hbcd_pkg::SETUP_FBA_BIT]};

  // ------------------------------------------------------------
  // Gate truth table and off-diagnosis arming per channel
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_ch
      // Command from pins or control bits
      assign on_cmd[g] = st_reg.command[hbcd_pkg::COMMAND_PIN_BIT] ?
                         direct_drive_input[g] : st_reg.command[g];
      // High and low gates wanted
      always_comb begin
        want_high[g] = 1'b0;
        want_low[g]  = 1'b0;
        if (st_reg.enable[g] && !st_reg.ot_flag[g/2] && !st_reg.oc_flag[g]) begin
          if (mode[g]) begin
            want_high[g] = on_cmd[g];
            want_low[g]  = free[g] & ~on_cmd[g];
          end else begin
            want_low[g]  = on_cmd[g];
            want_high[g] = free[g] & ~on_cmd[g];
          end
        end
      end
      // Armed when both gates off in the way freewheel demands
      assign diag_act[g] = !st_reg.gate[g].high_on && !st_reg.gate[g].low_on &&
                           (free[g] ? !st_reg.enable[g] : (!st_reg.enable[g] || !on_cmd[g]));
      assign diag_ready[g] = (st_reg.act_cnt[g] >= CW'(DIAG_ACT_CYC)) &&
                             (st_reg.filt_cnt[g] >= 4'(hbcd_pkg::DIAG_FILT_CYC));
    end
  endgenerate

  // ------------------------------------------------------------
  // Present detection codes, single and full bridge
  // ------------------------------------------------------------
  always_comb begin
    logic a_ol;
    logic a_sh;
    logic b_ol;
    logic b_sh;
    logic both;
    live_diag = st_reg.diag;
    a_ol = 1'b0;
    a_sh = 1'b0;
    b_ol = 1'b0;
    b_sh = 1'b0;
    both = 1'b0;
    for (int c = 0; c < 4; c++) begin
      if (diag_ready[c]) begin
        if (sense[c].short_off)
          live_diag[2*c +: 2] = hbcd_pkg::DIAG_SHORT;
        else if (sense[c].open_load)
          live_diag[2*c +: 2] = mode[c] ? hbcd_pkg::DIAG_OL_HS : hbcd_pkg::DIAG_OL_LS;
        else
          live_diag[2*c +: 2] = hbcd_pkg::DIAG_NONE;
      end
    end
    for (int p = 0; p < 2; p++) begin
      a_sh = sense[2*p].short_off;
      b_sh = sense[2*p+1].short_off;
      a_ol = sense[2*p].open_load;
      b_ol = sense[2*p+1].open_load;
      both = diag_ready[2*p] && diag_ready[2*p+1];
      if (fb_en[p]) begin
        live_diag[4*p +: 4] = st_reg.diag[4*p +: 4];
        if (both) begin
          // Short flags mean battery on high-side mode, ground otherwise, when the other half shows a fault too; a lone short gives ground on both
          if (b_sh && mode[2*p+1] && a_sh && mode[2*p])
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCB, hbcd_pkg::FB_SCB};
          else if (b_sh && mode[2*p+1] && a_sh)
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCB, hbcd_pkg::FB_SCG};
          else if (a_sh && mode[2*p] && (b_sh || b_ol))
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCG, hbcd_pkg::FB_SCB};
          else if (b_sh && mode[2*p+1] && a_ol)
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCB, hbcd_pkg::DIAG_NONE};
          else if (a_sh || b_sh)
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCG, hbcd_pkg::FB_SCG};
          else if (a_ol || b_ol)
            live_diag[4*p +: 4] = {hbcd_pkg::FB_SCG, hbcd_pkg::DIAG_NONE};
          else
            live_diag[4*p +: 4] = 4'h0;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  always_comb begin
    logic acc;
    logic wr_now;
    acc     = (avs_read || avs_write) && !st_reg.wait_n;
    wr_now  = avs_write && st_reg.wait_n;                     // Answer edge of a write
    st_next = st_reg;
    st_next.wait_n = acc;
    // Register writes land at the edge after waitrequest drops, which ends the access
    if (wr_now) begin
      for (int b = 0; b < 4; b++) begin
        if (avs_byteenable[b]) begin
          case (avs_address)
            hbcd_pkg::REG_SETUP:   st_next.setup[8*b +: 8] = avs_writedata[8*b +: 8];
            hbcd_pkg::REG_ENABLE:  if (b == 0) st_next.enable = avs_writedata[3:0];
            hbcd_pkg::REG_COMMAND: if (b == 0) st_next.command = avs_writedata[4:0];
            default: ;
          endcase
        end
      end
      // Disabling a channel releases its overcurrent latch
      if (avs_address == hbcd_pkg::REG_ENABLE && avs_byteenable[0])
        st_next.oc_flag = st_reg.oc_flag & avs_writedata[3:0];
    end
    // Register reads
    if (acc && avs_read) begin
      case (avs_address)
        hbcd_pkg::REG_SETUP:   st_next.rdata = st_reg.setup;
        hbcd_pkg::REG_ENABLE:  st_next.rdata = {28'h000_0000, st_reg.enable};
        hbcd_pkg::REG_COMMAND: st_next.rdata = {27'h000_0000, st_reg.command};
        hbcd_pkg::REG_OFFDIAG: st_next.rdata = {24'h00_0000, st_reg.diag};
        hbcd_pkg::REG_FAULT:   st_next.rdata = {26'h000_0000, st_reg.ot_flag, st_reg.oc_flag};
        default:               st_next.rdata = 32'h0000_0000;
      endcase
    end
    // Diagnosis register follows detection every cycle; reads do not refresh it
    if (acc && avs_read && avs_address == hbcd_pkg::REG_OFFDIAG)
      st_next.diag = live_diag;
    else
      st_next.diag = live_diag;
    // Overtemperature latches follow the sensor with its hysteresis
    st_next.ot_flag = overtemp_pair;
    for (int c = 0; c < 4; c++) begin
      // Overcurrent filter
      if (sense[c].oc && (st_reg.gate[c].high_on || st_reg.gate[c].low_on)) begin
        if (st_reg.oc_cnt[c] >= 4'(hbcd_pkg::OC_FILT_CYC - 1))
          st_next.oc_flag[c] = 1'b1;
        else
          st_next.oc_cnt[c] = st_reg.oc_cnt[c] + 4'h1;
      end else begin
        st_next.oc_cnt[c] = 4'h0;
      end
      // Activation timer and disturbance filter
      if (diag_act[c]) begin
        if (st_reg.act_cnt[c] < CW'(DIAG_ACT_CYC))
          st_next.act_cnt[c] = st_reg.act_cnt[c] + CW'(1);
        if (st_reg.filt_cnt[c] < 4'(hbcd_pkg::DIAG_FILT_CYC))
          st_next.filt_cnt[c] = st_reg.filt_cnt[c] + 4'h1;
      end else begin
        st_next.act_cnt[c]  = '0;
        st_next.filt_cnt[c] = 4'h0;
      end
      // Gate phase with break before make
      st_next.gate[c] = '0;
      case (st_reg.phase[c])
        hbcd_pkg::HBCD_OFF: begin
          if (want_high[c])      st_next.phase[c] = hbcd_pkg::HBCD_HIGH;
          else if (want_low[c])  st_next.phase[c] = hbcd_pkg::HBCD_LOW;
        end
        hbcd_pkg::HBCD_HIGH: begin
          if (!want_high[c]) begin
            st_next.phase[c]    = want_low[c] ? hbcd_pkg::HBCD_DEAD : hbcd_pkg::HBCD_OFF;
            st_next.dead_cnt[c] = 5'h00;
          end else
            st_next.gate[c].high_on = 1'b1;
        end
        hbcd_pkg::HBCD_LOW: begin
          if (!want_low[c]) begin
            st_next.phase[c]    = want_high[c] ? hbcd_pkg::HBCD_DEAD : hbcd_pkg::HBCD_OFF;
            st_next.dead_cnt[c] = 5'h00;
          end else
            st_next.gate[c].low_on = 1'b1;
        end
        hbcd_pkg::HBCD_DEAD: begin
          if (st_reg.dead_cnt[c] >= 5'(hbcd_pkg::BBM_CYC - 1))
            st_next.phase[c] = hbcd_pkg::HBCD_OFF;
          else
            st_next.dead_cnt[c] = st_reg.dead_cnt[c] + 5'h01;
        end
        default: st_next.phase[c] = hbcd_pkg::HBCD_OFF;
      endcase
      // Enable low or fault: immediate off (tristate)
      if (!want_high[c] && !want_low[c])
        st_next.gate[c] = '0;
    end
  end

  // ------------------------------------------------------------
  // State register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk or negedge resetn) begin
    if (!resetn) begin
      st_reg         <= '0;
      st_reg.setup   <= hbcd_pkg::SETUP_RST;
      st_reg.enable  <= hbcd_pkg::ENABLE_RST;
      st_reg.command <= hbcd_pkg::COMMAND_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign avs_readdata    = st_reg.rdata;
  assign avs_waitrequest = ~st_reg.wait_n;
  assign gate            = st_reg.gate;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  generate
    for (g = 0; g < 4; g++) begin : g_chk
      sequence s_high_drop;
        $fell(st_reg.gate[g].high_on);
      endsequence
      never_both_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !(gate[g].high_on && gate[g].low_on)) else $error("both gates on");
      dead_gap_a: assert property (@(posedge core_clk) disable iff (!resetn)
        s_high_drop |-> (!gate[g].low_on) [*2]) else $error("no dead time");
      en_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !st_reg.enable[g] |=> !gate[g].high_on && !gate[g].low_on) else $error("disabled gate on");
      passive_ls_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !mode[g] && !free[g] |=> !gate[g].high_on) else $error("passive ls high on");
      passive_hs_a: assert property (@(posedge core_clk) disable iff (!resetn)
        mode[g] && !free[g] |=> !gate[g].low_on) else $error("passive hs low on");
      oc_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
        st_reg.oc_flag[g] |=> !gate[g].high_on && !gate[g].low_on) else $error("oc gate on");
      act_wait_a: assert property (@(posedge core_clk) disable iff (!resetn)
        !diag_ready[g] |=> $stable(st_reg.diag[2*g +: 2])) else $error("early diag");
    end
  endgenerate
  ot_off_a: assert property (@(posedge core_clk) disable iff (!resetn)
    st_reg.ot_flag[0] |=> gate[1:0] == 4'h0) else $error("ot gate on");
  wait_one_a: assert property (@(posedge core_clk) disable iff (!resetn)
    avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("read not answered");

endmodule

`default_nettype wire

// ==== shared/hbcd_pkg.sv ====
// Package of the half-bridge control and diagnosis block.
// Holds register map, field layout, reset values and timing counts.
// Assumes a 25 MHz core clock.
package hbcd_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ        = 25;                // Core clock rate
  localparam int BBM_NS         = 1000;              // Dead time between sides
  localparam int BBM_CYC        = (BBM_NS * CLK_MHZ + 999) / 1000;
  localparam int OC_FILT_NS     = 500;               // Overcurrent filter, least time
  localparam int OC_FILT_CYC    = (OC_FILT_NS * CLK_MHZ + 999) / 1000;
  localparam int DIAG_ACT_US    = 60;                // Diag activation time, least
  localparam int DIAG_ACT_CYC   = DIAG_ACT_US * CLK_MHZ;
  localparam int DIAG_FILT_NS   = 500;               // Diag disturbance filter, least
  localparam int DIAG_FILT_CYC  = (DIAG_FILT_NS * CLK_MHZ + 999) / 1000;

  // ------------------------------------------------------------
  // Register map (word addresses; word index is byte address bits 4:2)
  // ------------------------------------------------------------
  localparam logic [2:0] REG_SETUP   = 3'h0;         // bridge_setup_register
  localparam logic [2:0] REG_ENABLE  = 3'h1;         // output_enable_register_two
  localparam logic [2:0] REG_COMMAND = 3'h2;         // output_command_register_two
  localparam logic [2:0] REG_OFFDIAG = 3'h3;         // bridge_off_diag_register
  localparam logic [2:0] REG_FAULT   = 3'h4;         // bridge_fault_register

  // Setup register fields
  localparam int SETUP_MODE_LSB  = 0;                // bridge_switch_mode_bit [3:0]
  localparam int SETUP_FREE_LSB  = 4;                // bridge_freewheel_active_bit [7:4]
  localparam int SETUP_FBA_BIT   = 8;                // pair_a_full_bridge_flag
  localparam int SETUP_FBB_BIT   = 9;                // pair_b_full_bridge_flag
  localparam int COMMAND_PIN_BIT = 4;                // Select pins instead of command bits

  // Fault register fields
  localparam int FAULT_OC_LSB    = 0;                // bridge_overcurrent_flag [3:0]
  localparam int FAULT_OTA_BIT   = 4;                // pair_a_overtemp_flag
  localparam int FAULT_OTB_BIT   = 5;                // pair_b_overtemp_flag

  // Reset values
  localparam logic [31:0] SETUP_RST   = 32'h0000_0000;
  localparam logic [3:0]  ENABLE_RST  = 4'h0;
  localparam logic [4:0]  COMMAND_RST = 5'h00;

  // Off diagnosis codes
  localparam logic [1:0] DIAG_NONE    = 2'h0;        // No failure
  localparam logic [1:0] DIAG_OL_HS   = 2'h1;        // Open load, high-side mode
  localparam logic [1:0] DIAG_OL_LS   = 2'h2;        // Open load, low-side mode
  localparam logic [1:0] DIAG_SHORT   = 2'h3;        // Short in off
  localparam logic [1:0] FB_SCB       = 2'h2;        // Full bridge: battery short
  localparam logic [1:0] FB_SCG       = 2'h1;        // Full bridge: ground short / OL

  // Gate phase of one channel
  typedef enum logic [1:0] {
    HBCD_OFF,
    HBCD_LOW,
    HBCD_HIGH,
    HBCD_DEAD
  } hbcd_phase_e;

  // Analog comparator results of one channel
  typedef struct packed {
    logic oc;                                        // Overcurrent comparator
    logic open_load;                                 // Open load in off
    logic short_off;                                 // Short in off (mode dependent)
  } hbcd_sense_s;

  // Gate drive of one channel
  typedef struct packed {
    logic high_on;                                   // High-side gate
    logic low_on;                                    // Low-side gate
  } hbcd_gate_s;

endpackage

// ==== tb/hbcd_load_model.sv ====
// Load and comparator model at the four half-bridge outputs.
// Assumes the bench chooses which fault each channel carries.
`timescale 1ns/10ps
`default_nettype none
module hbcd_load_model (
  input  wire hbcd_pkg::hbcd_gate_s  [3:0] gate,      // Gate drives from the block
  input  wire logic                  [3:0] hard_short, // Short while conducting
  input  wire logic                  [3:0] open_wire,  // Load missing
  input  wire logic                  [3:0] off_short,  // Short seen while off
  output var  hbcd_pkg::hbcd_sense_s [3:0] sense       // Comparator results
);
  // ------------------------------------------------------------
  // Comparators: current only flows while a side conducts
  // ------------------------------------------------------------
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      sense[i].oc        = hard_short[i] & (gate[i].high_on | gate[i].low_on);
      sense[i].open_load = open_wire[i] & ~(gate[i].high_on | gate[i].low_on);
      sense[i].short_off = off_short[i] & ~(gate[i].high_on | gate[i].low_on);
    end
  end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Self-checking bench for the half-bridge control and diagnosis block.
// Assumes the block answers Avalon-MM accesses and a load model senses.
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checks_done++; if ((s) !== (e)) begin bad_count++; \
  $display("FAIL %s exp %h got %h", nm, e, s); end end
module testbench;
  localparam int ACT = 20;                 // Short activation time
  logic                          core_clk, resetn, avs_read, avs_write;
  logic [2:0]                    avs_address;
  logic [31:0]                   avs_writedata, avs_readdata, q;
  logic                          avs_waitrequest;
  logic [3:0]                    ddi, hard_short, open_wire, off_short;
  logic [1:0]                    overtemp_pair;
  hbcd_pkg::hbcd_sense_s [3:0]   sense;
  hbcd_pkg::hbcd_gate_s  [3:0]   gate;
  int                            bad_count, checks_done;
  logic [1:0]                    w;
  // ------------------------------------------------------------
  // Block and load
  // ------------------------------------------------------------
  hbcd_core #(.DIAG_ACT_CYC(ACT)) DUT (.core_clk(core_clk), .resetn(resetn),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .direct_drive_input(ddi), .sense(sense),
    .overtemp_pair(overtemp_pair), .gate(gate));
  hbcd_load_model load (.gate(gate), .hard_short(hard_short), .open_wire(open_wire),
    .off_short(off_short), .sense(sense));
  // ------------------------------------------------------------
  // Clock and shoot-through monitor
  // ------------------------------------------------------------
  always #20 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    for (int i = 0; i < 4; i++) begin
      if (gate[i].high_on === 1'b1 && gate[i].low_on === 1'b1) begin
        `CHK("both_sides", 1'b0, 1'b1)
      end
    end
  end
  // ------------------------------------------------------------
  // Bus access: hold until waitrequest low, then release
  // ------------------------------------------------------------
  task automatic acc(input logic wr, input logic [2:0] a, input logic [31:0] d);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= ~wr;
    do @(posedge core_clk);
    while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge core_clk);
  endtask
  // Drive setup, enable and command words one after another
  task automatic cfg(input logic [31:0] s, input logic [3:0] e, input logic [4:0] c);
    acc(1'b1, 3'h0, s);
    acc(1'b1, 3'h1, {28'h000_0000, e});
    acc(1'b1, 3'h2, {27'h000_0000, c});
  endtask
  // Expected {high, low} of one channel
  function automatic logic [1:0] want(logic m, logic f, logic e, logic o);
    if (!e) return 2'b00;
    if (!m) return o ? 2'b01 : (f ? 2'b10 : 2'b00);
    return o ? 2'b10 : (f ? 2'b01 : 2'b00);
  endfunction
  // Verdict and end of run
  task automatic print_verdict;
    if (bad_count == 0 && checks_done > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    #800000;
    bad_count++;
    print_verdict;
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    core_clk = 0; resetn = 0; avs_read = 0; avs_write = 0; avs_address = 3'h0;
    avs_writedata = 32'h0000_0000; ddi = 4'h0; hard_short = 4'h0; open_wire = 4'h0;
    off_short = 4'h0; overtemp_pair = 2'h0; bad_count = 0; checks_done = 0;
    repeat (5) @(posedge core_clk);
    resetn <= 1'b1;
    acc(1'b0, 3'h0, 32'h0000_0000);
    `CHK("setup_rst", hbcd_pkg::SETUP_RST, q)
    acc(1'b0, 3'h7, 32'h0000_0000);
    `CHK("unmapped", 32'h0000_0000, q)
    acc(1'b0, 3'h3, 32'h0000_0000);
    acc(1'b0, 3'h3, 32'h0000_0000);
    `CHK("diag_start", 32'h0000_0000, q)
    // Every mode, freewheel, enable and command combination
    for (int k = 0; k < 16; k++) begin
      cfg({24'h00_0000, {4{k[2]}}, {4{k[3]}}}, {4{k[1]}}, {1'b0, {4{k[0]}}});
      repeat (40) @(posedge core_clk);
      w = want(k[3], k[2], k[1], k[0]);
      `CHK("gate_table", {4{w}}, gate)
    end
    // Direct pins select the command
    ddi <= 4'h5;
    cfg(32'h0000_000F, 4'hF, 5'h10);
    repeat (30) @(posedge core_clk);
    `CHK("direct_pins", 8'h22, gate)
    // Overcurrent trips, latches, clears by disable
    cfg(32'h0000_0000, 4'hF, 5'h01);
    hard_short <= 4'h1;
    repeat (60) @(posedge core_clk);
    `CHK("oc_off", 2'b00, gate[0])
    acc(1'b0, 3'h4, 32'h0000_0000);
    `CHK("oc_flag", 32'h0000_0001, q)
    hard_short <= 4'h0;
    acc(1'b1, 3'h1, 32'h0000_0000);
    acc(1'b1, 3'h1, 32'h0000_000F);
    repeat (30) @(posedge core_clk);
    `CHK("oc_clear", 2'b01, gate[0])
    // Overtemperature on pair A only
    acc(1'b1, 3'h2, 32'h0000_000F);
    overtemp_pair <= 2'b01;
    repeat (30) @(posedge core_clk);
    `CHK("ot_off", 8'h50, gate)
    acc(1'b0, 3'h4, 32'h0000_0000);
    `CHK("ot_flag", 32'h0000_0010, q)
    overtemp_pair <= 2'b00;
    repeat (30) @(posedge core_clk);
    `CHK("ot_back", 8'h55, gate)
    // Off diagnosis, low-side then high-side mode
    open_wire <= 4'h1;
    off_short <= 4'h2;
    for (int m = 0; m < 2; m++) begin
      // Conduct first so the activation timer restarts from zero
      acc(1'b1, 3'h2, 32'h0000_000F);
      repeat (40) @(posedge core_clk);
      cfg({28'h000_0000, {4{m[0]}}}, 4'hF, 5'h00);
      repeat (3) @(posedge core_clk);
      acc(1'b0, 3'h3, 32'h0000_0000);
      // Early read still shows the previous pass
      w = m[0] ? hbcd_pkg::DIAG_OL_LS : hbcd_pkg::DIAG_NONE;
      `CHK("diag_early", {28'h000_0000, m[0] ? hbcd_pkg::DIAG_SHORT : 2'h0, w}, q)
      repeat (ACT + 40) @(posedge core_clk);
      acc(1'b0, 3'h3, 32'h0000_0000);
      acc(1'b0, 3'h3, 32'h0000_0000);
      w = m[0] ? hbcd_pkg::DIAG_OL_HS : hbcd_pkg::DIAG_OL_LS;
      `CHK("diag_code", {28'h000_0000, hbcd_pkg::DIAG_SHORT, w}, q)
    end
    open_wire <= 4'h0;
    off_short <= 4'h0;
    repeat (ACT + 40) @(posedge core_clk);
    acc(1'b0, 3'h3, 32'h0000_0000);
    `CHK("diag_fresh", 32'h0000_0000, q)
    // Full bridge on both pairs: open load at pair A second channel
    acc(1'b1, 3'h0, 32'h0000_0300);
    open_wire <= 4'h2;
    repeat (ACT + 40) @(posedge core_clk);
    acc(1'b0, 3'h3, 32'h0000_0000);
    `CHK("fb_open", {28'h000_0000, hbcd_pkg::FB_SCG, hbcd_pkg::DIAG_NONE}, q)
    // Ground short at first, battery short at second (high-side mode)
    acc(1'b1, 3'h0, 32'h0000_0302);
    open_wire <= 4'h0;
    off_short <= 4'h3;
    repeat (ACT + 40) @(posedge core_clk);
    acc(1'b0, 3'h3, 32'h0000_0000);
    acc(1'b0, 3'h3, 32'h0000_0000);
    `CHK("fb_double", {28'h000_0000, hbcd_pkg::FB_SCB, hbcd_pkg::FB_SCG}, q)
    `CHK("fb_valid", 1'b0, q[3:2] == 2'b11 || q[1:0] == 2'b11)
    print_verdict;
  end
endmodule
`default_nettype wire
